// ==== design/rxl_lock_ctrl.sv ====
// Purpose: receive signal detect, recovery loop lock sequencing, loss output and data mute
// Assumes: analog loop reports reference lock and recovered-frequency tolerance as levels
// Notes:   serial_rx_in is one recovered bit per pclk; APB slave, zero wait states
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "rxl_map.svh"

// Summary of operation
// - strap low selects pin configuration; strap high selects register configuration.
// - both configuration sources drive the same logic; settings source differs, and the status loss bit reads 0 in pin mode.
// - reference select 0 picks low reference, 1 picks doubled reference.
// - error-correction references keep the same ratio; the other party supplies them.
// - recovered bits are gathered into 4-bit parallel words at quarter rate.
// - parallel receive clock is the bit clock divided by four.
// - after reset, loss of signal or loss of lock, retrain on reference.
// - first lock to reference, only then try to follow incoming data.
// - recovered frequency out of tolerance returns to reference and drops lock flag.
// - parallel receive clock keeps running during loss of lock or signal.
// - signal detect showing absence also declares loss of lock.
// - signal present and frequency in tolerance resumes tracking and raises lock flag.
// - loss condition is signal detect xor polarity, feeding output, loop and mute.
// - loss output high while signal absent; host mode status updated too.
// - with mute enabled, data outputs are zero throughout a loss condition.
// - polarity 0 means detect low is presence, polarity 1 means detect high.
module rxl_lock_ctrl
  import rxl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        config_source_select,
  input  wire logic        pin_ref_freq_select,
  input  wire logic        pin_mute_on_loss_enable,
  input  wire logic        pin_polarity,
  input  wire logic        module_signal_detect,
  input  wire logic        serial_rx_in,
  input  wire logic        ref_train_ok,
  input  wire logic        rec_freq_ok,
  output logic             ref_freq_select,
  output logic [5:0]       pll_mult,
  output logic             loop_on_reference,
  output logic             recovery_locked_flag,
  output logic             signal_loss_out,
  output logic [3:0]       parallel_rx_data_out,
  output logic             parallel_rx_clock_out,
  output logic             irq
);

  localparam int unsigned SETTLE_CYC = `RXL_SETTLE_CYC;

  // ************************************************************
  // strap capture
  // ************************************************************
  logic        host_mode_reg;
  logic        host_mode_next;
  logic        strap_done_reg;
  logic        strap_done_next;

  // strap taken once after reset release, not under the async reset
  always_comb begin
    host_mode_next  = host_mode_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg) begin
      host_mode_next = config_source_select;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_mode_reg  <= 1'b0;
      strap_done_reg <= 1'b0;
    end else begin
      host_mode_reg  <= host_mode_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // ************************************************************
  // registers and APB
  // ************************************************************
  rxl_cfg_s    ctrl_reg;
  rxl_cfg_s    ctrl_next;
  rxl_evt_s    int_stat_reg;
  rxl_evt_s    int_stat_next;
  rxl_evt_s    int_mask_reg;
  rxl_evt_s    int_mask_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        err_reg;
  logic        err_next;
  logic        status_loss_reg;
  logic        status_loss_next;
  rxl_evt_s    evt;
  rxl_state_e  state_reg;
  rxl_state_e  state_next;
  logic        wr_en;
  logic        setup;
  logic        mapped;

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite;

  // ************************************************************
  // address decode
  // ************************************************************
  logic        hit_ctrl;
  logic        hit_status;
  logic        hit_int_stat;
  logic        hit_int_mask;

  always_comb begin
    hit_ctrl     = (paddr == `RXL_OFS_CTRL);
    hit_status   = (paddr == `RXL_OFS_STATUS);
    hit_int_stat = (paddr == `RXL_OFS_INT_STAT);
    hit_int_mask = (paddr == `RXL_OFS_INT_MASK);
    mapped       = hit_ctrl || hit_status || hit_int_stat || hit_int_mask;
  end

  // ************************************************************
  // control and mask registers
  // ************************************************************
  always_comb begin
    ctrl_next     = ctrl_reg;
    int_mask_next = int_mask_reg;
    if (wr_en && hit_ctrl) begin
      ctrl_next = pwdata[2:0];
    end
    if (wr_en && hit_int_mask) begin
      int_mask_next = pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= `RXL_CTRL_RESET;
      int_mask_reg <= `RXL_MASK_RESET;
    end else begin
      ctrl_reg     <= ctrl_next;
      int_mask_reg <= int_mask_next;
    end
  end

  // ************************************************************
  // sticky interrupt status
  // ************************************************************
  always_comb begin
    int_stat_next = int_stat_reg;
    if (wr_en && hit_int_stat) begin
      int_stat_next = int_stat_reg & ~pwdata[2:0];
    end
    // a new event outranks a clear in the same cycle
    int_stat_next = int_stat_next | evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= 3'h0;
    end else begin
      int_stat_reg <= int_stat_next;
    end
  end

  // ************************************************************
  // read data and error
  // ************************************************************
  always_comb begin
    prdata_next = prdata_reg;
    err_next    = err_reg;
    if (setup) begin
      err_next    = !mapped;
      prdata_next = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `RXL_OFS_CTRL:     prdata_next[2:0] = ctrl_reg;
          `RXL_OFS_STATUS: begin
            prdata_next[`RXL_ST_LOSS]                        = status_loss_reg;
            prdata_next[`RXL_ST_LOCKED]                      = recovery_locked_flag;
            prdata_next[`RXL_ST_HOST]                        = host_mode_reg;
            prdata_next[`RXL_ST_STATE_LO+1:`RXL_ST_STATE_LO] = state_reg;
          end
          `RXL_OFS_INT_STAT: prdata_next[2:0] = int_stat_reg;
          `RXL_OFS_INT_MASK: prdata_next[2:0] = int_mask_reg;
          default:           prdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      err_reg    <= err_next;
    end
  end

  // read data and error are set up in the setup cycle, so no wait states
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = psel && penable && err_reg;
  assign irq     = |(int_stat_reg & int_mask_reg);

  // ************************************************************
  // configuration source and loss condition
  // ************************************************************
  rxl_cfg_s    cfg;
  logic        signal_loss_condition;

  always_comb begin
    // one settings word feeds every function, whatever its source
    if (host_mode_reg) begin
      cfg = ctrl_reg;
    end else begin
      cfg.polarity = pin_polarity;
      cfg.mute_en  = pin_mute_on_loss_enable;
      cfg.ref_freq = pin_ref_freq_select;
    end
  end

  // polarity 1: detect high means presence; polarity 0: detect low means presence
  assign signal_loss_condition = module_signal_detect ^ cfg.polarity;

  // both reference options give the same line rate, also at the error-correction rate
  assign ref_freq_select = cfg.ref_freq;
  assign pll_mult        = cfg.ref_freq ? `RXL_MULT_HIGH_REF : `RXL_MULT_LOW_REF;

  // ************************************************************
  // recovery loop lock sequencing
  // ************************************************************
  logic [15:0] settle_reg;
  logic [15:0] settle_next;
  logic        locked_reg;
  logic        locked_next;
  logic        loss_reg;
  logic        loss_next;

  always_comb begin
    state_next  = state_reg;
    settle_next = settle_reg;
    unique case (state_reg)
      RXL_ST_REF_ACQ: begin
        settle_next = 16'h0000;
        if (ref_train_ok && !signal_loss_condition) begin
          state_next = RXL_ST_DATA_ACQ;
        end
      end
      RXL_ST_DATA_ACQ: begin
        settle_next = settle_reg + 16'h0001;
        if (signal_loss_condition || !ref_train_ok) begin
          state_next = RXL_ST_REF_ACQ;
        end else if (settle_reg >= 16'(SETTLE_CYC - 1) && rec_freq_ok) begin
          state_next = RXL_ST_LOCKED;
        end else if (settle_reg >= 16'(SETTLE_CYC - 1)) begin
          state_next = RXL_ST_REF_ACQ;
        end
      end
      RXL_ST_LOCKED: begin
        settle_next = 16'h0000;
        if (signal_loss_condition || !rec_freq_ok) begin
          state_next = RXL_ST_REF_ACQ;
        end
      end
      default: state_next = RXL_ST_REF_ACQ;
    endcase
    locked_next      = (state_next == RXL_ST_LOCKED);
    loss_next        = signal_loss_condition;
    status_loss_next = host_mode_reg ? signal_loss_condition : 1'b0;
  end

  // one-cycle events for the sticky status; loss only on its rising edge
  always_comb begin
    evt.loss      = signal_loss_condition && !loss_reg;
    evt.lock_lost = locked_reg && !locked_next;
    evt.lock_gain = !locked_reg && locked_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= RXL_ST_REF_ACQ;
      settle_reg      <= 16'h0000;
      locked_reg      <= 1'b0;
      loss_reg        <= 1'b0;
      status_loss_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      settle_reg      <= settle_next;
      locked_reg      <= locked_next;
      loss_reg        <= loss_next;
      status_loss_reg <= status_loss_next;
    end
  end

  assign recovery_locked_flag = locked_reg;
  assign loop_on_reference    = !locked_reg;
  assign signal_loss_out      = loss_reg;

  // ************************************************************
  // deserializer, divider and mute
  // ************************************************************
  logic [1:0]  div_reg;
  logic [1:0]  div_next;
  logic [3:0]  shift_reg;
  logic [3:0]  shift_next;
  logic [3:0]  data_reg;
  logic [3:0]  data_next;
  logic        pclk_out_reg;
  logic        pclk_out_next;

  // divider free-runs so the framer never loses its clock
  always_comb begin
    div_next      = div_reg + 2'h1;
    pclk_out_next = div_next[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg      <= 2'h0;
      pclk_out_reg <= 1'b0;
    end else begin
      div_reg      <= div_next;
      pclk_out_reg <= pclk_out_next;
    end
  end

  // limitation: after a muted stretch zeros stand until the next word boundary
  always_comb begin
    shift_next    = {shift_reg[2:0], serial_rx_in};
    data_next     = data_reg;
    if (div_reg == 2'h3) begin
      // first bit of the word lands in the msb
      if (cfg.mute_en && signal_loss_condition) begin
        data_next = 4'h0;
      end else begin
        data_next = shift_next;
      end
    end else if (cfg.mute_en && signal_loss_condition) begin
      data_next = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 4'h0;
      data_reg  <= 4'h0;
    end else begin
      shift_reg <= shift_next;
      data_reg  <= data_next;
    end
  end

  assign parallel_rx_data_out  = data_reg;
  assign parallel_rx_clock_out = pclk_out_reg;

endmodule

// ==== design/rxl_map.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the rx lock control
// Assumes: 32-bit APB, pclk at 250 MHz
// Notes:   definitions only
`ifndef RXL_MAP_SVH
`define RXL_MAP_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define RXL_OFS_CTRL       8'h00
`define RXL_OFS_STATUS     8'h04
`define RXL_OFS_INT_STAT   8'h08
`define RXL_OFS_INT_MASK   8'h0c

// ************************************************************
// field positions
// ************************************************************
`define RXL_CTRL_REF_FREQ  0
`define RXL_CTRL_MUTE_EN   1
`define RXL_CTRL_POLARITY  2
`define RXL_ST_LOSS        0
`define RXL_ST_LOCKED      1
`define RXL_ST_HOST        2
`define RXL_ST_STATE_LO    4
`define RXL_INT_LOSS       0
`define RXL_INT_LOCK_LOST  1
`define RXL_INT_LOCK_GAIN  2

// ************************************************************
// reset values
// ************************************************************
`define RXL_CTRL_RESET     3'h0
`define RXL_MASK_RESET     3'h0

// ************************************************************
// timing and ratios
// ************************************************************
`define RXL_CLK_MHZ        250
`define RXL_SETTLE_NS      1000
`define RXL_SETTLE_CYC     ((`RXL_SETTLE_NS * `RXL_CLK_MHZ) / 1000)
`define RXL_MULT_LOW_REF   6'h20
`define RXL_MULT_HIGH_REF  6'h10
`define RXL_DESER_WIDTH    4

`endif

// ==== design/rxl_pkg.sv ====
// Purpose: types of the rx lock control
// Assumes: nothing
// Notes:   constants live in rxl_map.svh
package rxl_pkg;

  typedef enum logic [1:0] {
    RXL_ST_REF_ACQ,
    RXL_ST_DATA_ACQ,
    RXL_ST_LOCKED
  } rxl_state_e;

  typedef struct packed {
    logic polarity;
    logic mute_en;
    logic ref_freq;
  } rxl_cfg_s;

  typedef struct packed {
    logic lock_gain;
    logic lock_lost;
    logic loss;
  } rxl_evt_s;

endpackage

// ==== sim/rxl_lock_ctrl_monitor.sv ====
// Purpose: port-level checks of the rx lock control
// Assumes: pin configuration while the strap is low
// Notes:   bound into rxl_lock_ctrl
`timescale 1ns/100ps
`include "rxl_map.svh"
module rxl_lock_ctrl_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       config_source_select,
  input wire logic       pin_mute_on_loss_enable,
  input wire logic       pin_polarity,
  input wire logic       module_signal_detect,
  input wire logic       ref_train_ok,
  input wire logic       rec_freq_ok,
  input wire logic       ref_freq_select,
  input wire logic [5:0] pll_mult,
  input wire logic       loop_on_reference,
  input wire logic       recovery_locked_flag,
  input wire logic       signal_loss_out,
  input wire logic [3:0] parallel_rx_data_out,
  input wire logic       parallel_rx_clock_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****
  // checks
  // ****
  AST_LOOP_REF: assert property (loop_on_reference == !recovery_locked_flag)
    else $error("loop reference flag wrong");
  AST_LOSS_XOR: assert property ($past(presetn) && !config_source_select |->
    signal_loss_out == $past(module_signal_detect ^ pin_polarity)) else $error("loss output wrong");
  AST_LOCK_CAUSE: assert property ($rose(recovery_locked_flag) |->
    $past(rec_freq_ok) && $past(ref_train_ok, 2)) else $error("lock without cause");
  AST_FREQ_DROP: assert property (recovery_locked_flag && !rec_freq_ok |=> !recovery_locked_flag)
    else $error("lock kept off frequency");
  AST_LOSS_DROP: assert property (signal_loss_out |=> !recovery_locked_flag)
    else $error("lock kept during loss");
  AST_MUTE: assert property (!config_source_select && pin_mute_on_loss_enable && $past(pin_mute_on_loss_enable)
    && signal_loss_out && $past(signal_loss_out) |-> parallel_rx_data_out == 4'h0) else $error("data not muted");
  AST_RXCLK: assert property ($rose(parallel_rx_clock_out) |->
    ##2 $fell(parallel_rx_clock_out) ##2 $rose(parallel_rx_clock_out)) else $error("rx clock not div4");
  AST_PLL: assert property (pll_mult == (ref_freq_select ? `RXL_MULT_HIGH_REF : `RXL_MULT_LOW_REF))
    else $error("multiplier wrong");
  cover property ($rose(recovery_locked_flag));
  cover property (signal_loss_out && parallel_rx_data_out == 4'h0);
  cover property ($fell(recovery_locked_flag) && !signal_loss_out);
endmodule
bind rxl_lock_ctrl rxl_lock_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .config_source_select(config_source_select), .pin_mute_on_loss_enable(pin_mute_on_loss_enable),
  .pin_polarity(pin_polarity), .module_signal_detect(module_signal_detect), .ref_train_ok(ref_train_ok),
  .rec_freq_ok(rec_freq_ok), .ref_freq_select(ref_freq_select), .pll_mult(pll_mult),
  .loop_on_reference(loop_on_reference), .recovery_locked_flag(recovery_locked_flag),
  .signal_loss_out(signal_loss_out), .parallel_rx_data_out(parallel_rx_data_out),
  .parallel_rx_clock_out(parallel_rx_clock_out));

// ==== sim/rxl_optics_model.sv ====
// Purpose: optical module and loop status as seen by the rx lock control
// Assumes: bench steers light, polarity and loop health
// Notes:   serial bits random, one per pclk
`timescale 1ns/100ps
module rxl_optics_model (
  input  wire logic pclk,
  input  wire logic present,
  input  wire logic polarity,
  input  wire logic freq_good,
  input  wire logic train_good,
  output logic      module_signal_detect,
  output logic      serial_rx_in,
  output logic      ref_train_ok,
  output logic      rec_freq_ok
);
  // presence shows as detect equal to the module's polarity
  assign module_signal_detect = present ? polarity : !polarity;
  assign ref_train_ok = train_good;
  assign rec_freq_ok = freq_good;
  initial serial_rx_in = 1'b0;
  always @(posedge pclk) serial_rx_in <= 1'($urandom);
endmodule

// ==== sim/rx_signal_detect_lock_control_bench.sv ====
// Purpose: self-checking bench of the rx lock control
// Assumes: zero-wait APB, strap changed only under reset
// Notes:   pin mode first, host mode last
`timescale 1ns/100ps
`include "rxl_map.svh"
module rx_signal_detect_lock_control_bench
  import rxl_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, strap, pin_ref, pin_mute, pin_pol;
  logic        present, pol, freq_good, train_good, mute_exp, clk_d, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  logic [3:0]  hist;
  wire  [31:0] prdata;
  wire  [5:0]  pll_mult;
  wire  [3:0]  rx_data;
  wire         pready, pslverr, ref_sel, loop_ref, locked, loss_out, rx_clk, irq, det, ser, tr_ok, fr_ok;
  int          err_count, n_checks, cyc, quiet;
  rxl_lock_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .config_source_select(strap), .pin_ref_freq_select(pin_ref), .pin_mute_on_loss_enable(pin_mute),
    .pin_polarity(pin_pol), .module_signal_detect(det), .serial_rx_in(ser), .ref_train_ok(tr_ok),
    .rec_freq_ok(fr_ok), .ref_freq_select(ref_sel), .pll_mult(pll_mult), .loop_on_reference(loop_ref),
    .recovery_locked_flag(locked), .signal_loss_out(loss_out), .parallel_rx_data_out(rx_data),
    .parallel_rx_clock_out(rx_clk), .irq(irq));
  rxl_optics_model optics (.pclk(pclk), .present(present), .polarity(pol), .freq_good(freq_good),
    .train_good(train_good), .module_signal_detect(det), .serial_rx_in(ser), .ref_train_ok(tr_ok),
    .rec_freq_ok(fr_ok));
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task end_of_test;
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task settle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // bounded wait: the settle count is 250 cycles
  task wait_lock(input logic exp);
    for (int i = 0; i < 300 && locked !== exp; i++) @(negedge pclk);
    chk("lock_flag", {31'h0, exp}, {31'h0, locked});
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    hist <= {hist[2:0], ser};
    cyc <= cyc + 1;
  end
  // words are only compared well clear of a muted stretch
  always @(negedge pclk) begin
    quiet = (((!present || loss_out) && mute_exp) || !presetn) ? 0 : quiet + 1;
    if (clk_d && !rx_clk && quiet > 8) chk("rx_word", {28'h0, hist}, {28'h0, rx_data});
    clk_d = rx_clk;
    if (cyc == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    logic [2:0] r;
    {psel, penable, pwrite, strap, pin_ref, pin_mute, pin_pol, pol, mute_exp, clk_d, presetn} = '0;
    {present, freq_good, train_good} = 3'h7;
    paddr = 8'h00; pwdata = 32'h0; hist = 4'h0; cyc = 0; quiet = 0; err_count = 0; n_checks = 0;
    r = 3'($urandom(32));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      r = 3'($urandom);
      @(posedge pclk);
      pin_pol <= r[2]; pol <= r[2]; pin_mute <= r[1]; mute_exp <= r[1]; pin_ref <= r[0];
      present <= 1'b1; freq_good <= 1'b1;
      wait_lock(1'b1);
      chk("ref_sel", {31'h0, r[0]}, {31'h0, ref_sel});
      @(posedge pclk);
      present <= 1'b0;
      settle(3);
      chk("loss_out", 32'h1, {31'h0, loss_out});
      chk("lock_on_loss", 32'h0, {31'h0, locked});
      if (r[1]) chk("rx_muted", 32'h0, {28'h0, rx_data});
      @(posedge pclk);
      present <= 1'b1;
      wait_lock(1'b1);
      @(posedge pclk);
      freq_good <= 1'b0;
      settle(2);
      chk("loop_ref", 32'h1, {31'h0, loop_ref});
    end
    @(posedge pclk);
    train_good <= 1'b0; freq_good <= 1'b1;
    settle(300);
    chk("untrained", 32'h0, {31'h0, locked});
    @(posedge pclk);
    presetn <= 1'b0; strap <= 1'b1; train_good <= 1'b1; {pin_ref, pin_mute, pin_pol, pol, mute_exp} <= '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `RXL_OFS_STATUS, 32'h0);
    chk("host_bit", 32'h1, {31'h0, rd[`RXL_ST_HOST]});
    apb(1'b1, `RXL_OFS_CTRL, 32'h7);
    pol <= 1'b1; mute_exp <= 1'b1;
    settle(2);
    chk("ref_sel_host", 32'h1, {31'h0, ref_sel});
    apb(1'b0, `RXL_OFS_CTRL, 32'h0);
    chk("ctrl_rd", 32'h7, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b1, `RXL_OFS_INT_STAT, 32'h7);
    apb(1'b1, `RXL_OFS_INT_MASK, 32'h1);
    present <= 1'b0;
    settle(4);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b0, `RXL_OFS_STATUS, 32'h0);
    chk("st_loss", 32'h1, {31'h0, rd[`RXL_ST_LOSS]});
    apb(1'b1, `RXL_OFS_INT_STAT, 32'h1);
    apb(1'b1, `RXL_OFS_INT_MASK, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq});
    present <= 1'b1;
    settle(5);
    @(posedge pclk);
    present <= 1'b0;
    settle(4);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b0, `RXL_OFS_INT_STAT, 32'h0);
    chk("stat_sticky", 32'h1, {31'h0, rd[`RXL_INT_LOSS]});
    present <= 1'b1;
    wait_lock(1'b1);
    end_of_test;
  end
endmodule
